// ---- hdl/fnd_device.sv ----
`timescale 1ns/100ps
module fnd_device
	import fnd_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	fnd_link_if.device link,
	input wire logic reference_input,
	output logic [10:0] feed_count,
	output logic [21:0] active_numerator,
	output logic [21:0] active_fraction_base,
	output logic [3:0] pump_gain_code,
	output logic [4:0] pump_multiple,
	output logic [5:0] ref_divide,
	output logic wide_fraction_select,
	output logic [1:0] modulator_order,
	output logic integer_mode,
	output logic cal_start,
	output logic pd_tick,
	output logic [10:0] cycle_count
);

	// ==========================================
	// word decode
	logic [3:0] sel;
	logic wr_zero;
	logic wr_one;
	logic wr_two;
	logic wr_three;

	assign sel = link.cfg_word[SEL_W-1:0];
	assign wr_zero = link.cfg_strobe && (sel == SEL_WORD_ZERO);
	assign wr_one = link.cfg_strobe && (sel == SEL_WORD_ONE);
	assign wr_two = link.cfg_strobe && (sel == SEL_WORD_TWO);
	assign wr_three = link.cfg_strobe && (sel == SEL_WORD_THREE);

	// ==========================================
	// staged high parts; not used until the low word lands
	logic [N_HI_W-1:0] n_hi_stage;
	logic [HI_W-1:0] num_hi_stage;
	logic [HI_W-1:0] base_hi_stage;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			n_hi_stage <= N_RESET[N_W-1:N_LO_W];
			num_hi_stage <= FRAC_RESET[FRAC_W-1:LO_W];
		end else if (wr_one) begin
			n_hi_stage <= link.cfg_word[N_HI_POS +: N_HI_W];
			num_hi_stage <= link.cfg_word[NUM_HI_POS +: HI_W];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			base_hi_stage <= FRAC_RESET[FRAC_W-1:LO_W];
		end else if (wr_three) begin
			base_hi_stage <= link.cfg_word[BASE_HI_POS +: HI_W];
		end
	end

	// ==========================================
	// applied settings
	logic [21:0] numerator;
	logic [21:0] fraction_base;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			feed_count <= N_RESET;
			numerator <= FRAC_RESET;
		end else if (wr_zero) begin
			feed_count <= {n_hi_stage, link.cfg_word[N_LO_POS +: N_LO_W]};
			numerator <= {num_hi_stage, link.cfg_word[NUM_LO_POS +: LO_W]};
		end
	end

	// calibration kicks on every word zero, even a repeat
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cal_start <= 1'b0;
		end else begin
			cal_start <= wr_zero;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pump_gain_code <= PUMP_RESET;
			pump_multiple <= 5'h01;
		end else if (wr_one) begin
			pump_gain_code <= link.cfg_word[PUMP_POS +: PUMP_W];
			pump_multiple <= {1'b0, link.cfg_word[PUMP_POS +: PUMP_W]} + 5'h01;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fraction_base <= FRAC_RESET;
			ref_divide <= REF_RESET;
		end else if (wr_two) begin
			fraction_base <= {base_hi_stage, link.cfg_word[BASE_LO_POS +: LO_W]};
			ref_divide <= link.cfg_word[REF_POS +: REF_W];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wide_fraction_select <= 1'b0;
			modulator_order <= ORDER_RESET;
		end else if (wr_three) begin
			wide_fraction_select <= link.cfg_word[WIDE_POS];
			modulator_order <= link.cfg_word[ORDER_POS +: ORDER_W];
		end
	end

	// narrow mode masks the high ten bits of both words
	assign active_numerator = wide_fraction_select ? numerator
		: {{HI_W{1'b0}}, numerator[LO_W-1:0]};
	assign active_fraction_base = wide_fraction_select ? fraction_base
		: {{HI_W{1'b0}}, fraction_base[LO_W-1:0]};
	assign integer_mode = (modulator_order == ORDER_INTEGER);

	// ==========================================
	// legality report; settings still apply, but the reference divider holds at zero while ref_divide is illegal
	logic ref_ok;

	assign ref_ok = fnd_ref_legal(ref_divide);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			link.dev_status <= '0;
		end else begin
			link.dev_status[ST_N_BAD] <= (feed_count < N_MIN) || (feed_count > N_MAX);
			link.dev_status[ST_REF_BAD] <= !ref_ok;
			link.dev_status[ST_ALIGN_BAD] <=
				fnd_align_bad(ref_divide, active_fraction_base[1:0]);
			link.dev_status[ST_BASE_ZERO] <=
				!integer_mode && (active_fraction_base == FRAC_RESET);
			link.dev_status[ST_BASE_ONE] <=
				!integer_mode && (active_fraction_base == FRAC_ONE);
		end
	end

	// ==========================================
	// reference divider
	logic ref_meta;
	logic ref_sync;
	logic ref_prev;
	logic ref_rise;
	logic [5:0] ref_count;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ref_meta <= 1'b0;
			ref_sync <= 1'b0;
			ref_prev <= 1'b0;
		end else begin
			ref_meta <= reference_input;
			ref_sync <= ref_meta;
			ref_prev <= ref_sync;
		end
	end

	assign ref_rise = ref_sync && !ref_prev;

	// reference must stay below half of mclk to be seen
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ref_count <= 6'h00;
			pd_tick <= 1'b0;
		end else begin
			pd_tick <= 1'b0;
			if (!ref_ok) begin
				ref_count <= 6'h00;
			end else if (ref_rise) begin
				if (ref_count >= ref_divide - 6'h01) begin
					ref_count <= 6'h00;
					pd_tick <= 1'b1;
				end else begin
					ref_count <= ref_count + 6'h01;
				end
			end
		end
	end

	// ==========================================
	// first-order fraction accumulator
	logic [21:0] acc;
	logic [22:0] sum;
	logic carry;

	assign sum = {1'b0, acc} + {1'b0, active_numerator};
	assign carry = (active_fraction_base != FRAC_RESET) && (sum >= {1'b0, active_fraction_base});

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			acc <= FRAC_RESET;
			cycle_count <= N_RESET;
		end else if (integer_mode) begin
			acc <= FRAC_RESET;
			if (pd_tick) begin
				cycle_count <= feed_count;
			end
		end else if (pd_tick) begin
			if (carry) begin
				acc <= 22'(sum - {1'b0, active_fraction_base});
				cycle_count <= feed_count + 11'h001;
			end else begin
				acc <= sum[21:0];
				cycle_count <= feed_count;
			end
		end
	end

endmodule : fnd_device

// ---- include/fnd_pkg.sv ----
// ==========================================
// fractional-N divider settings: shared definitions
package fnd_pkg;

	// ==========================================
	// configuration word layout
	localparam int WORD_W = 24;
	localparam int SEL_W = 4;
	localparam logic [3:0] SEL_WORD_ZERO = 4'h0;
	localparam logic [3:0] SEL_WORD_ONE = 4'h1;
	localparam logic [3:0] SEL_WORD_TWO = 4'h2;
	localparam logic [3:0] SEL_WORD_THREE = 4'h3;

	// config_word_zero
	localparam int N_LO_POS = 16;
	localparam int N_LO_W = 8;
	localparam int NUM_LO_POS = 4;
	localparam int LO_W = 12;
	// config_word_one
	localparam int PUMP_POS = 17;
	localparam int PUMP_W = 4;
	localparam int N_HI_POS = 14;
	localparam int N_HI_W = 3;
	localparam int NUM_HI_POS = 4;
	localparam int HI_W = 10;
	// config_word_two
	localparam int BASE_LO_POS = 10;
	localparam int REF_POS = 4;
	localparam int REF_W = 6;
	// config_word_three
	localparam int WIDE_POS = 22;
	localparam int ORDER_POS = 18;
	localparam int ORDER_W = 2;
	localparam int BASE_HI_POS = 4;

	localparam int N_W = N_HI_W + N_LO_W;
	localparam int FRAC_W = HI_W + LO_W;

	// ==========================================
	// limits and codes
	localparam logic [10:0] N_MIN = 11'h037;
	localparam logic [10:0] N_MAX = 11'h7F7;
	localparam logic [1:0] ORDER_INTEGER = 2'h1;
	localparam logic [5:0] REF_DIV_16 = 6'h10;
	localparam logic [5:0] REF_DIV_32 = 6'h20;
	localparam logic [21:0] FRAC_ONE = 22'h00_0001;

	// ==========================================
	// reset values
	localparam logic [10:0] N_RESET = 11'h037;
	localparam logic [21:0] FRAC_RESET = 22'h00_0000;
	localparam logic [5:0] REF_RESET = 6'h01;
	localparam logic [3:0] PUMP_RESET = 4'h0;
	localparam logic [1:0] ORDER_RESET = 2'h1;

	// ==========================================
	// device status bits sent back over the link
	localparam int ST_W = 5;
	localparam int ST_N_BAD = 0;
	localparam int ST_REF_BAD = 1;
	localparam int ST_ALIGN_BAD = 2;
	localparam int ST_BASE_ZERO = 3;
	localparam int ST_BASE_ONE = 4;

	// ==========================================
	// host register map (AHB-Lite byte offsets)
	localparam logic [7:0] HOST_CMD_OFS = 8'h00;
	localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
	localparam int HST_REFUSED = 0;
	localparam int HST_DEV_POS = 1;

	function automatic logic fnd_ref_legal(input logic [5:0] r);
		return (r != 6'h00) && ((r & (r - 6'h01)) == 6'h00);
	endfunction : fnd_ref_legal

	// even denominator at 16, multiple of four at 32
	function automatic logic fnd_align_bad(input logic [5:0] r, input logic [1:0] base_lsb);
		return ((r == REF_DIV_16) && base_lsb[0]) || ((r == REF_DIV_32) && (base_lsb != 2'h0));
	endfunction : fnd_align_bad

endpackage : fnd_pkg

// ---- include/fnd_link_if.sv ----
`timescale 1ns/100ps
// ==========================================
// word-level configuration link, serial framing left out
interface fnd_link_if;
	logic [23:0] cfg_word;
	logic cfg_strobe;
	logic [4:0] dev_status;

	modport host (
		output cfg_word,
		output cfg_strobe,
		input dev_status
	);

	modport device (
		input cfg_word,
		input cfg_strobe,
		output dev_status
	);
endinterface : fnd_link_if

// ---- hdl/fnd_host.sv ----
`timescale 1ns/100ps
module fnd_host
	import fnd_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	fnd_link_if.host link
);

	// ==========================================
	// AHB-Lite slave, zero wait states
	logic dp_write;
	logic [7:0] dp_addr;
	logic ap_valid;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ap_valid = hsel && hready && htrans[1] && (hsize == 3'h2);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			dp_write <= ap_valid && hwrite;
			dp_addr <= haddr[7:0];
		end
	end

	// ==========================================
	// shadows of what the device holds, for the legality check
	logic [N_HI_W-1:0] sh_n_hi;
	logic [HI_W-1:0] sh_base_hi;
	logic sh_wide;
	logic [1:0] sh_order;
	logic [23:0] w;
	logic [3:0] sel;
	logic [10:0] n_new;
	logic [21:0] base_new;
	logic [5:0] r_new;
	logic ok;
	logic send;
	logic refused;

	assign w = hwdata[23:0];
	assign sel = w[SEL_W-1:0];
	assign n_new = {sh_n_hi, w[N_LO_POS +: N_LO_W]};
	assign r_new = w[REF_POS +: REF_W];
	assign base_new = sh_wide ? {sh_base_hi, w[BASE_LO_POS +: LO_W]}
		: {{HI_W{1'b0}}, w[BASE_LO_POS +: LO_W]};

	always_comb begin
		ok = 1'b0;
		case (sel)
			SEL_WORD_ZERO: ok = (n_new >= N_MIN) && (n_new <= N_MAX);
			SEL_WORD_ONE: ok = 1'b1;
			SEL_WORD_TWO: ok = fnd_ref_legal(r_new)
				&& !fnd_align_bad(r_new, base_new[1:0])
				&& ((sh_order == ORDER_INTEGER)
				|| ((base_new != FRAC_RESET) && (base_new != FRAC_ONE)));
			SEL_WORD_THREE: ok = 1'b1;
			default: ok = 1'b0;
		endcase
	end

	assign send = dp_write && (dp_addr == HOST_CMD_OFS) && ok;
	assign refused = dp_write && (dp_addr == HOST_CMD_OFS) && !ok;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sh_n_hi <= N_RESET[N_W-1:N_LO_W];
			sh_base_hi <= FRAC_RESET[FRAC_W-1:LO_W];
			sh_wide <= 1'b0;
			sh_order <= ORDER_RESET;
		end else if (send && (sel == SEL_WORD_ONE)) begin
			sh_n_hi <= w[N_HI_POS +: N_HI_W];
		end else if (send && (sel == SEL_WORD_THREE)) begin
			sh_base_hi <= w[BASE_HI_POS +: HI_W];
			sh_wide <= w[WIDE_POS];
			sh_order <= w[ORDER_POS +: ORDER_W];
		end
	end

	// ==========================================
	// link drive
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			link.cfg_word <= 24'h00_0000;
			link.cfg_strobe <= 1'b0;
		end else begin
			link.cfg_strobe <= send;
			if (send) begin
				link.cfg_word <= w;
			end
		end
	end

	// ==========================================
	// refused flag: a new refusal beats a same-cycle clear
	logic refused_flag;
	logic clear_refused;

	assign clear_refused = dp_write && (dp_addr == HOST_STATUS_OFS) && hwdata[HST_REFUSED];

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			refused_flag <= 1'b0;
		end else if (refused) begin
			refused_flag <= 1'b1;
		end else if (clear_refused) begin
			refused_flag <= 1'b0;
		end
	end

	// read data latched in the address phase
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			case (haddr[7:0])
				HOST_CMD_OFS: hrdata <= {8'h00, link.cfg_word};
				HOST_STATUS_OFS: hrdata <= {26'h000_0000, link.dev_status, refused_flag};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : fnd_host

// ---- verif/fnd_link_asserts.sv ----
`timescale 1ns/100ps
module fnd_link_asserts
	import fnd_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [23:0] cfg_word,
	input wire logic cfg_strobe,
	input wire logic [4:0] dev_status
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ==========================================
	// shadow of the applied settings
	logic [23:0] w1, w3;
	logic [10:0] n;
	logic [5:0] r;
	logic [21:0] base, abase;
	logic [4:0] exp_st;
	logic frac;
	wire logic [3:0] sel = cfg_word[3:0];
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			w1 <= 24'h00_0000;
			w3 <= 24'h04_0000;
			n <= N_RESET;
			r <= REF_RESET;
			base <= FRAC_RESET;
		end else if (cfg_strobe) begin
			if (sel == SEL_WORD_ZERO) n <= {w1[16:14], cfg_word[23:16]};
			if (sel == SEL_WORD_ONE) w1 <= cfg_word;
			if (sel == SEL_WORD_TWO) r <= cfg_word[9:4];
			if (sel == SEL_WORD_TWO) base <= {w3[13:4], cfg_word[21:10]};
			if (sel == SEL_WORD_THREE) w3 <= cfg_word;
		end
	end
	always_comb begin
		frac = w3[19:18] != ORDER_INTEGER;
		abase = w3[22] ? base : {10'h000, base[11:0]};
		exp_st[ST_N_BAD] = n < N_MIN || n > N_MAX;
		exp_st[ST_REF_BAD] = !(r inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20});
		exp_st[ST_ALIGN_BAD] = (r == REF_DIV_16 && base[0]) || (r == REF_DIV_32 && base[1:0] != 2'h0);
		exp_st[ST_BASE_ZERO] = frac && abase == 22'h00_0000;
		exp_st[ST_BASE_ONE] = frac && abase == FRAC_ONE;
	end
	// ==========================================
	// device flags follow the applied values
	n_flag_a: assert property (dev_status[ST_N_BAD] == $past(exp_st[ST_N_BAD]))
		else $error("feed count flag wrong");
	ref_flag_a: assert property (dev_status[ST_REF_BAD] == $past(exp_st[ST_REF_BAD]))
		else $error("ref divide flag wrong");
	align_flag_a: assert property (dev_status[ST_ALIGN_BAD] == $past(exp_st[2]))
		else $error("alignment flag wrong");
	zero_flag_a: assert property (dev_status[ST_BASE_ZERO] == $past(exp_st[3]))
		else $error("zero base flag wrong");
	one_flag_a: assert property (dev_status[ST_BASE_ONE] == $past(exp_st[4]))
		else $error("unit base flag wrong");
	// ==========================================
	// host never sends an illegal word
	host_n_a: assert property (cfg_strobe && sel == SEL_WORD_ZERO |->
		{w1[16:14], cfg_word[23:16]} inside {[N_MIN:N_MAX]}) else $error("bad count sent");
	host_ref_a: assert property (cfg_strobe && sel == SEL_WORD_TWO |->
		cfg_word[9:4] inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20}) else $error("bad ref sent");
	host_align_a: assert property (cfg_strobe && sel == SEL_WORD_TWO |->
		!((cfg_word[9:4] == REF_DIV_16 && cfg_word[10]) ||
		(cfg_word[9:4] == REF_DIV_32 && cfg_word[11:10] != 2'h0))) else $error("bad base sent");
	word_hold_a: assert property (!cfg_strobe |-> $stable(cfg_word) && sel <= SEL_WORD_THREE)
		else $error("word moved without strobe");
	cover property (cfg_strobe && sel == SEL_WORD_ZERO);
	cover property (dev_status[ST_BASE_ZERO]);
	cover property (cfg_strobe && sel == SEL_WORD_TWO && cfg_word[9:4] == REF_DIV_32);
endmodule : fnd_link_asserts

// ---- verif/fractional_n_divider_config_tb_top.sv ----
`timescale 1ns/100ps
module fractional_n_divider_config_tb_top
	import fnd_pkg::*;
;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic reference_input = 1'b0;
	logic [2:0] refc = 3'h0;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, wide_fraction_select, integer_mode, cal_start, pd_tick;
	wire logic [10:0] feed_count, cycle_count;
	wire logic [21:0] active_numerator, active_fraction_base;
	wire logic [3:0] pump_gain_code;
	wire logic [4:0] pump_multiple;
	wire logic [5:0] ref_divide;
	wire logic [1:0] modulator_order;
	int num_errors = 0;
	int comparisons = 0;
	// model state; host copies of the last words 1 and 3 included
	int p1 = 0, p3 = 32'h0004_0000, n = 55, num = 0, base = 0, r = 1, ord = 1;
	int wide = 0, pump = 0, refused = 0, lastw = 0;
	fnd_link_if link();
	fnd_host u_fnd_host (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .link(link));
	fnd_device u_fnd_device (.mclk(mclk), .resetn(resetn), .link(link),
		.reference_input(reference_input), .feed_count(feed_count),
		.active_numerator(active_numerator), .active_fraction_base(active_fraction_base),
		.pump_gain_code(pump_gain_code), .pump_multiple(pump_multiple), .ref_divide(ref_divide),
		.wide_fraction_select(wide_fraction_select), .modulator_order(modulator_order),
		.integer_mode(integer_mode), .cal_start(cal_start), .pd_tick(pd_tick),
		.cycle_count(cycle_count));
	fnd_link_asserts u_fnd_link_asserts (.mclk(mclk), .resetn(resetn), .cfg_word(link.cfg_word),
		.cfg_strobe(link.cfg_strobe), .dev_status(link.dev_status));
	always #25 mclk = ~mclk;
	// reference at mclk/8, well under the synchroniser limit
	always @(posedge mclk) begin
		refc <= refc + 3'h1;
		reference_input <= refc[2];
	end
	// ==========================================
	// reporting
	task automatic tally_and_finish;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	// ==========================================
	// bus master
	task automatic wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (hready !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : wait_rdy
	task automatic ahb(input bit wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge mclk);
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : ahb
	// ==========================================
	// model
	function automatic bit legal(input int w);
		int rr, dd;
		rr = w >> 4 & 63;
		dd = (p3[22] ? (p3 >> 4 & 1023) << 12 : 0) | w >> 10 & 4095;
		case (w & 15)
			0: return ((p1 >> 14 & 7) << 8 | w >> 16 & 255) inside {[55:2039]};
			1, 3: return 1;
			2: return rr inside {1, 2, 4, 8, 16, 32} && !(rr == 16 && dd % 2)
				&& !(rr == 32 && dd % 4) && ((p3 >> 18 & 3) == 1 || dd > 1);
			default: return 0;
		endcase
	endfunction : legal
	function automatic int stat();
		int ab;
		ab = wide ? base : base % 4096;
		return (n < 55 || n > 2039) | !(r inside {1, 2, 4, 8, 16, 32}) << 1
			| ((r == 16 && base % 2) || (r == 32 && base % 4)) << 2
			| (ord != 1 && ab == 0) << 3 | (ord != 1 && ab == 1) << 4;
	endfunction : stat
	task automatic cmp_dev(input bit cal);
		check("feed_count", feed_count, n);
		check("numerator", active_numerator, wide ? num : num % 4096);
		check("base", active_fraction_base, wide ? base : base % 4096);
		check("pump", {pump_gain_code, pump_multiple}, pump << 5 | pump + 1);
		check("ref", ref_divide, r);
		check("mode", {wide_fraction_select, modulator_order, integer_mode},
			wide << 3 | ord << 1 | ord == 1);
		check("cal", cal_start, cal);
	endtask : cmp_dev
	task automatic send(input logic [23:0] w);
		int s;
		bit ok;
		logic [31:0] rd;
		s = w & 15;
		ok = legal(w);
		ahb(1'b1, HOST_CMD_OFS, {8'h00, w}, rd);
		if (!ok) refused = 1;
		else if (s == 0) begin
			n = (p1 >> 14 & 7) << 8 | w >> 16;
			num = (p1 >> 4 & 1023) << 12 | w >> 4 & 4095;
		end else if (s == 1) begin
			p1 = w;
			pump = w >> 17 & 15;
		end else if (s == 2) begin
			r = w >> 4 & 63;
			base = (p3 >> 4 & 1023) << 12 | w >> 10 & 4095;
		end else begin
			p3 = w;
			wide = w[22];
			ord = w >> 18 & 3;
		end
		if (ok) lastw = w;
		@(negedge mclk);
		@(negedge mclk);
		cmp_dev(ok && s == 0);
		ahb(1'b0, HOST_STATUS_OFS, 32'h0000_0000, rd);
		check("status", rd, stat() << 1 | refused);
	endtask : send
	// sum of counts over eight phase-detector cycles
	task automatic measure(input int want);
		int k, t, s;
		bit d;
		t = 0;
		s = 0;
		d = 0;
		for (k = 0; k < 400 && t < 8; k++) begin
			@(negedge mclk);
			if (d) s += cycle_count;
			d = pd_tick;
			t += pd_tick;
		end
		@(negedge mclk);
		s += cycle_count;
		check("ticks", t, 8);
		check("cycle_sum", s, want);
	endtask : measure
	// ==========================================
	// main sequence
	logic [23:0] tbl [21] = '{24'h04_0003, 24'h00_0822, 24'h0A_0001, 24'h64_0010, 24'h0C_0003,
		24'h36_0000, 24'h37_0000, 24'h01_C001, 24'hF7_0000, 24'hF8_0000, 24'h00_1A02,
		24'h00_2202, 24'h00_0D02, 24'h00_0412, 24'h00_0005, 24'h4C_0013, 24'h00_0012,
		24'h0C_0013, 24'h00_3FF1, 24'h37_FFF0, 24'h4C_0013};
	initial begin
		logic [31:0] rd;
		void'($urandom(3));
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		cmp_dev(1'b0);
		check("hresp", hresp, 0);
		ahb(1'b0, HOST_STATUS_OFS, 32'h0000_0000, rd);
		check("status", rd, 0);
		ahb(1'b0, 8'h08, 32'h0000_0000, rd);
		check("unmapped", rd, 0);
		foreach (tbl[i]) begin
			send(tbl[i]);
			if (i == 3) measure(800);
			if (i == 4) measure(804);
		end
		ahb(1'b1, HOST_STATUS_OFS, 32'h0000_0001, rd);
		refused = 0;
		for (int i = 0; i < 64; i++) begin
			send(24'(i % 16) << 17 | 24'h00_0001);
			send(24'h00_2002 | 24'(i) << 4);
		end
		for (int i = 0; i < 40; i++) send(24'($urandom) & 24'hFF_FFF0 | 24'($urandom % 5));
		// byte-sized write must be dropped, so the readback still shows lastw
		hsize <= 3'h0;
		ahb(1'b1, HOST_CMD_OFS, 32'h0000_0001, rd);
		hsize <= 3'h2;
		ahb(1'b0, HOST_CMD_OFS, 32'h0000_0000, rd);
		check("cmd", rd, lastw);
		tally_and_finish();
	end
endmodule : fractional_n_divider_config_tb_top
